/* shared/csel_regs.vh */
`ifndef CSEL_REGS_VH
`define CSEL_REGS_VH
// clock rate and timing figures
`define CSEL_CLK_HZ 250000000
`define CSEL_GRACE_MS 1000
`define CSEL_GRACE_CYC ((`CSEL_CLK_HZ / 1000) * `CSEL_GRACE_MS)
`define CSEL_DLY_MS_DEF 0
// counter width, enough for many seconds
`define CSEL_CNT_W 40
// evaluation methods
`define CSEL_MODE_COMP 1'b0
`define CSEL_MODE_ONEHOT 1'b1
// case numbering, 2 bits for cases 1..4 stored as 0..3
`define CSEL_CASE_W 2
`define CSEL_CASE_RST 2'h0
`define CSEL_NCH 4
`endif

/* core/csel_decode.v */
`timescale 1ns/10ps
`include "csel_regs.vh"
// decodes the synchronised channel pattern to a case number
module csel_decode (
    // channels, order a1 a2 b1 b2 in bits 0..3
    input wire [3:0] chan,
    input wire mode,
    // result
    output reg valid,
    output reg [1:0] case_no
);
    // complementary pairs give two bits, one-hot gives one of four
    always @* begin
        valid = 1'b0;
        case_no = `CSEL_CASE_RST;
        if (mode == `CSEL_MODE_COMP) begin
            // ch one high, ch two low is 0; reversed is 1; equal is error
            valid = (chan[0] ^ chan[1]) & (chan[2] ^ chan[3]);
            case_no = {chan[3], chan[1]};
        end else begin
            case (chan)
                4'h1: begin
                    valid = 1'b1;
                    case_no = 2'h0;
                end
                4'h2: begin
                    valid = 1'b1;
                    case_no = 2'h1;
                end
                4'h4: begin
                    valid = 1'b1;
                    case_no = 2'h2;
                end
                4'h8: begin
                    valid = 1'b1;
                    case_no = 2'h3;
                end
                default: begin
                    valid = 1'b0;
                    case_no = `CSEL_CASE_RST;
                end
            endcase
        end
    end
endmodule // csel_decode

/* core/csel_top.v */
`timescale 1ns/10ps
`include "csel_regs.vh"
module csel_top #(
    parameter [39:0] GRACE_CYC = `CSEL_GRACE_CYC
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // static control input channels from the pins
    input wire input_a_channel_one,
    input wire input_a_channel_two,
    input wire input_b_channel_one,
    input wire input_b_channel_two,
    // configuration straps
    input wire mode_onehot,
    input wire onehot_present,
    input wire seq_mon_en,
    input wire [39:0] on_delay_cyc,
    // scanner status
    input wire field_clear,
    input wire dev_error,
    // restart request, level from logic
    input wire restart,
    // results
    output wire safety_switching_output_one,
    output wire safety_switching_output_two,
    output reg [1:0] active_case,
    output reg case_error,
    output reg restart_needed
);
    localparam ST_RUN = 2'h0;
    localparam ST_DELAY = 2'h1;
    localparam ST_GRACE = 2'h2;
    localparam ST_LOCK = 2'h3;

    reg [3:0] sync1_r;
    reg [3:0] sync2_r;
    reg [3:0] last_r;
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [39:0] cnt_r;
    reg [39:0] cnt_nxt;
    reg [1:0] case_nxt;
    reg err_nxt;
    reg lock_nxt;
    reg out_on_r;
    reg off_r;
    reg off_nxt;
    wire [3:0] pins;
    wire mode;
    wire valid;
    wire [1:0] dec_case;

    assign pins = {input_b_channel_two, input_b_channel_one,
                   input_a_channel_two, input_a_channel_one};
    // one-hot honoured only where the variant has it
    assign mode = mode_onehot & onehot_present;

    // two-stage synchroniser for the pin channels
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= 4'h0;
            sync2_r <= 4'h0;
        end else begin
            sync1_r <= pins;
            sync2_r <= sync1_r;
        end
    end

    csel_decode u_dec (
        .chan(sync2_r),
        .mode(mode),
        .valid(valid),
        .case_no(dec_case)
    );

    // case selection sequence
    always @* begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case_nxt = active_case;
        err_nxt = case_error;
        lock_nxt = restart_needed;
        off_nxt = off_r;
        case (state_r)
            ST_RUN: begin
                if (sync2_r != last_r) begin
                    state_nxt = ST_DELAY;
                    cnt_nxt = 40'h0;
                end
            end
            ST_DELAY: begin
                if (sync2_r != last_r) begin
                    cnt_nxt = 40'h0; // restart delay on a new change
                end else if (cnt_r >= on_delay_cyc) begin
                    if (valid) begin
                        case_nxt = dec_case;
                        state_nxt = ST_RUN;
                    end else if (seq_mon_en) begin
                        off_nxt = 1'b1;
                        err_nxt = 1'b1;
                        lock_nxt = 1'b1;
                        state_nxt = ST_LOCK;
                    end else begin
                        off_nxt = 1'b1;
                        cnt_nxt = 40'h0;
                        state_nxt = ST_GRACE;
                    end
                end else begin
                    cnt_nxt = cnt_r + 40'h1;
                end
            end
            ST_GRACE: begin
                if (valid) begin
                    case_nxt = dec_case;
                    off_nxt = 1'b0;
                    state_nxt = ST_RUN;
                end else if (cnt_r >= GRACE_CYC - 40'h1) begin
                    err_nxt = 1'b1;
                    lock_nxt = 1'b1;
                    state_nxt = ST_LOCK;
                end else begin
                    cnt_nxt = cnt_r + 40'h1;
                end
            end
            default: begin
                // held off until restart
                if (restart) begin
                    err_nxt = 1'b0;
                    lock_nxt = 1'b0;
                    // stay off until a valid pattern is taken after the delay
                    off_nxt = 1'b1;
                    case_nxt = `CSEL_CASE_RST;
                    state_nxt = ST_DELAY;
                    cnt_nxt = 40'h0;
                end
            end
        endcase
    end

    // state registers
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_DELAY;
            cnt_r <= 40'h0;
            last_r <= 4'h0;
            active_case <= `CSEL_CASE_RST;
            case_error <= 1'b0;
            restart_needed <= 1'b0;
            off_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            last_r <= sync2_r;
            active_case <= case_nxt;
            case_error <= err_nxt;
            restart_needed <= lock_nxt;
            if (state_r == ST_DELAY && state_nxt == ST_RUN) begin
                off_r <= 1'b0;
            end else begin
                off_r <= off_nxt;
            end
        end
    end

    // output pair, high only when field clear and nothing wrong
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_on_r <= 1'b0;
        end else begin
            out_on_r <= field_clear & ~dev_error & ~off_nxt
                        & ~lock_nxt;
        end
    end

    assign safety_switching_output_one = out_on_r;
    assign safety_switching_output_two = out_on_r;
endmodule // csel_top

/* testbench/csel_assertions.sv */
`timescale 1ns/10ps
// port checker for the case selector
module csel_assertions (
    input wire clk, rst_n, mode_onehot, onehot_present,
    input wire input_a_channel_one, input_a_channel_two,
    input wire input_b_channel_one, input_b_channel_two,
    input wire field_clear, dev_error, restart,
    input wire safety_switching_output_one,
    input wire safety_switching_output_two,
    input wire [1:0] active_case,
    input wire case_error, restart_needed
);
    // pin pattern, a1 in bit 0
    wire [3:0] p = {input_b_channel_two, input_b_channel_one,
        input_a_channel_two, input_a_channel_one};
    wire o1 = safety_switching_output_one;
    wire oh = mode_onehot && onehot_present;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_pair; o1 == safety_switching_output_two; endproperty
    a_pair: assert property (p_pair) else $error("pair differs");
    property p_gate; (!field_clear || dev_error) [*2] |-> !o1; endproperty
    a_gate: assert property (p_gate) else $error("output on");
    property p_lock; restart_needed |-> !o1; endproperty
    a_lock: assert property (p_lock) else $error("on in lock");
    property p_err; $rose(case_error) |-> restart_needed; endproperty
    a_err: assert property (p_err) else $error("error no lock");
    property p_rst;
        $fell(restart_needed) |-> $past(restart) || $past(restart, 2);
    endproperty
    a_rst: assert property (p_rst) else $error("lock left");
    // only case changes while running; grace takes at once, restart waits out the delay
    property p_hold;
        $changed(active_case) && $past(o1) |-> $past(p, 3) == $past(p, 4);
    endproperty
    a_hold: assert property (p_hold) else $error("case early");
    property p_oh;
        $changed(active_case) && oh && !$past(restart_needed)
            |-> $past(p, 3) == 4'h1 << active_case;
    endproperty
    a_oh: assert property (p_oh) else $error("one-hot map");
    property p_comp;
        $changed(active_case) && !oh && !$past(restart_needed)
            |-> active_case ==
            {$past(input_b_channel_two, 3), $past(input_a_channel_two, 3)};
    endproperty
    a_comp: assert property (p_comp) else $error("pair map");
endmodule // csel_assertions

/* testbench/csel_ctl.sv */
`timescale 1ns/10ps
// safety controller: drives channel pins, watches the output pair
module csel_ctl (
    input wire [3:0] pat,
    input wire o1,
    input wire o2,
    output wire [3:0] ch,
    output wire safe,
    output wire mism
);
    // each channel from its own source bit
    assign ch = pat;
    // safe state when either output is off, each read apart
    assign safe = !o1 || !o2;
    // disagreement flag for the discrepancy timer
    assign mism = o1 ^ o2;
endmodule // csel_ctl

/* testbench/csel_top_tb_top.sv */
`timescale 1ns/10ps
module csel_top_tb_top;
    logic clk = 0, rst_n = 0, mo = 0, op = 1, sq = 0, fc = 1, de = 0, rs = 0;
    logic [3:0] pat = 4'h5;
    wire [3:0] ch;
    wire o1, o2, safe, mism, ce, rn;
    wire [1:0] ac;
    int n_mismatch = 0, total_checks = 0;
    initial forever #2 clk = ~clk;
    csel_ctl u_csel_ctl (.pat(pat), .o1(o1), .o2(o2), .ch(ch),
        .safe(safe), .mism(mism));
    csel_top #(.GRACE_CYC(40'h14)) u_csel_top (.clk(clk), .rst_n(rst_n),
        .input_a_channel_one(ch[0]), .input_a_channel_two(ch[1]),
        .input_b_channel_one(ch[2]), .input_b_channel_two(ch[3]),
        .mode_onehot(mo), .onehot_present(op), .seq_mon_en(sq),
        .on_delay_cyc(40'h5), .field_clear(fc), .dev_error(de),
        .restart(rs), .safety_switching_output_one(o1),
        .safety_switching_output_two(o2), .active_case(ac),
        .case_error(ce), .restart_needed(rn));
    task ck(string n, logic [3:0] e, logic [3:0] s);
        total_checks++;
        if (e !== s) begin
            n_mismatch++;
            $display("CHECK FAILED %s exp %h got %h", n, e, s);
        end
    endtask
    // new pattern at a falling edge, then n cycles
    task go(logic [3:0] p, int n);
        @(negedge clk);
        pat = p;
        repeat (n) @(negedge clk);
    endtask
    // clear a lockout with a fresh pattern
    task relock(logic [3:0] p);
        pat = p;
        rs = 1;
        go(p, 1);
        rs = 0;
        go(p, 20);
        ck("lock", 0, rn);
    endtask
    task t_comp;
        for (int c = 1; c < 5; c++) begin
            go({c[1], ~c[1], c[0], ~c[0]}, 3);
            ck("hold", c - 1, ac);
            repeat (17) @(negedge clk);
            ck("case", c & 3, ac);
            ck("on", 1, o1);
        end
        $display("t_comp done");
    endtask
    task t_field;
        fc = 0;
        go(pat, 2);
        ck("safe", 1, safe);
        fc = 1;
        de = 1;
        go(pat, 2);
        ck("out2", 0, o2);
        de = 0;
        go(pat, 2);
        ck("mism", 0, mism);
        $display("t_field done");
    endtask
    task t_grace;
        go(4'h7, 14);
        ck("off", 0, o1);
        ck("grace", 0, rn);
        go(4'h6, 14);
        ck("case", 1, ac);
        go(4'h0, 45);
        ck("err", 1, ce);
        ck("lock", 1, rn);
        relock(4'h5);
        ck("on", 1, o1);
        $display("t_grace done");
    endtask
    task t_seq;
        sq = 1;
        go(4'hf, 20);
        ck("lock", 1, rn);
        relock(4'h9);
        ck("case", 2, ac);
        $display("t_seq done");
    endtask
    task t_onehot;
        mo = 1;
        for (int c = 0; c < 4; c++) begin
            go(4'h1 << c, 20);
            ck("case", c, ac);
            ck("on", 1, o1);
        end
        go(4'h3, 20);
        ck("lock", 1, rn);
        relock(4'h1);
        sq = 0;
        op = 0;
        go(4'h9, 20);
        ck("case", 2, ac);
        $display("t_onehot done");
    endtask
    task results;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (16) @(negedge clk);
        rst_n = 1;
        t_comp;
        t_field;
        t_grace;
        t_seq;
        t_onehot;
        results;
    end
    // watchdog
    initial begin
        #20000;
        n_mismatch++;
        results;
    end
endmodule // csel_top_tb_top
bind csel_top csel_assertions u_csel_assertions (.*);
